// ---- design/fault_history_recorder.sv ----
`timescale 1ns/1ps
module fault_history_recorder #(
    parameter int TICK_CYCLES = fault_history_pkg::RUN_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    // Live measurements and fault events
    input  wire fault_history_pkg::meas_t         live_meas,
    input  wire logic                             drive_running,
    input  wire logic                             fault_event,
    input  wire logic [fault_history_pkg::DATA_W-1:0] fault_code,
    // Register port
    input  wire logic [fault_history_pkg::ADDR_W-1:0] addr,
    input  wire logic [fault_history_pkg::DATA_W-1:0] wdata,
    input  wire logic                             wr_en,
    input  wire logic                             rd_en,
    output logic      [fault_history_pkg::DATA_W-1:0] rdata
);
    import fault_history_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES) + 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [SEL_W-1:0]  DEPTH_SAT = SEL_W'(RECORD_DEPTH);

    meas_t              meas_q;
    fault_rec_t         records [RECORD_DEPTH];
    fault_rec_t         sel_rec;
    logic [SEL_W-1:0]   record_select;
    logic [SEL_W-1:0]   record_count;
    logic [TICK_W-1:0]  tick_cnt;
    logic               run_tick;
    logic [STAMP_W-1:0] run_time;
    logic               capture;
    logic [DATA_W-1:0]  next_rdata;

    // Live values are refreshed every cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meas_q <= '0;
        end else begin
            meas_q <= live_meas;
        end
    end

    // Divider for the 0.1 s running-time step
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            run_tick <= 1'b0;
        end else if (drive_running) begin
            run_tick <= (tick_cnt == TICK_LAST);
            if (tick_cnt == TICK_LAST) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end else begin
            run_tick <= 1'b0;
        end
    end

    // Wraps after about 13.6 years of running, as a 32-bit count must
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_time <= '0;
        end else if (run_tick) begin
            run_time <= run_time + 1'b1;
        end
    end

    AST_TICK_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
        !drive_running |=> !run_tick)
        else $error("running-time step while drive stopped");

    AST_RUN_STEP: assert property (@(posedge clock) disable iff (!rst_n)
        run_tick |=> run_time == $past(run_time) + 1'b1)
        else $error("running time did not advance on its step");

    AST_RUN_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !run_tick |=> $stable(run_time))
        else $error("running time moved without a step");

    // A zero code would read as an empty slot, so it is not recorded
    assign capture = fault_event && (fault_code != NO_FAULT_CODE);

    AST_ZERO_CODE_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
        fault_event && fault_code == NO_FAULT_CODE |=> $stable(records[0]))
        else $error("zero fault code was recorded");

    AST_CODE_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture |=> records[0].code == $past(fault_code) && records[0].valid)
        else $error("fault code not captured");

    AST_CODE_NONZERO: assert property (@(posedge clock) disable iff (!rst_n)
        records[0].valid |-> records[0].code != NO_FAULT_CODE)
        else $error("valid record holds the empty code");

    // Newest record, built from the latched snapshot
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            records[0] <= EMPTY_RECORD;
        end else if (capture) begin
            records[0].valid       <= 1'b1;
            records[0].code        <= fault_code;
            records[0].stamp       <= run_time;
            records[0].speed       <= meas_q.motor_speed;
            records[0].u_current   <= meas_q.u_current;
            records[0].v_current   <= meas_q.v_current;
            records[0].bus_voltage <= meas_q.bus_voltage;
        end
    end

    // Older records age by one place; the last one falls off
    for (genvar g = 1; g < RECORD_DEPTH; g++) begin : g_age
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                records[g] <= EMPTY_RECORD;
            end else if (capture) begin
                records[g] <= records[g-1];
            end
        end

        AST_AGE_STEP: assert property (@(posedge clock) disable iff (!rst_n)
            capture |=> records[g] == $past(records[g-1]))
            else $error("record did not take its younger neighbour");

        AST_AGE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
            !capture |=> $stable(records[g]))
            else $error("record aged without a fault");
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            record_count <= '0;
        end else if (capture && record_count != DEPTH_SAT) begin
            record_count <= record_count + 1'b1;
        end
    end

    AST_COUNT_SAT: assert property (@(posedge clock) disable iff (!rst_n)
        record_count <= DEPTH_SAT)
        else $error("fault count beyond record depth");

    AST_COUNT_EMPTY: assert property (@(posedge clock) disable iff (!rst_n)
        record_count == '0 |-> !records[0].valid)
        else $error("newest record valid with zero fault count");

    // Out-of-range selections are ignored rather than wrapped
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            record_select <= SEL_RESET;
        end else if (wr_en && addr == FAULT_RECORD_SELECT_IDX && wdata <= DATA_W'(SEL_MAX)) begin
            record_select <= wdata[SEL_W-1:0];
        end
    end

    AST_SELECT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !(wr_en && addr == FAULT_RECORD_SELECT_IDX) |=> $stable(record_select))
        else $error("record selector changed without a write");

    AST_SELECT_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == FAULT_RECORD_SELECT_IDX |=> rdata == DATA_W'($past(record_select)))
        else $error("record selector read back wrong");

    // Empty slots read as all zero
    always_comb begin
        sel_rec = records[record_select];
        if (!sel_rec.valid) begin
            sel_rec = EMPTY_RECORD;
        end
    end

    always_comb begin
        next_rdata = '0;
        case (addr)
            PHASE_CURRENT_RMS_IDX: begin
                next_rdata = meas_q.phase_current;
            end
            BUS_VOLTAGE_LIVE_IDX: begin
                next_rdata = meas_q.bus_voltage;
            end
            MODULE_TEMPERATURE_IDX: begin
                next_rdata = meas_q.temperature;
            end
            FAULT_RECORD_SELECT_IDX: begin
                next_rdata = DATA_W'(record_select);
            end
            SELECTED_FAULT_CODE_IDX: begin
                next_rdata = sel_rec.code;
            end
            STAMP_LOW_IDX: begin
                next_rdata = sel_rec.stamp[DATA_W-1:0];
            end
            STAMP_HIGH_IDX: begin
                next_rdata = sel_rec.stamp[STAMP_W-1:DATA_W];
            end
            FAULT_MOTOR_SPEED_IDX: begin
                next_rdata = sel_rec.speed;
            end
            FAULT_U_CURRENT_IDX: begin
                next_rdata = sel_rec.u_current;
            end
            FAULT_V_CURRENT_IDX: begin
                next_rdata = sel_rec.v_current;
            end
            FAULT_BUS_VOLTAGE_IDX: begin
                next_rdata = sel_rec.bus_voltage;
            end
            RUN_TIME_LOW_IDX: begin
                next_rdata = run_time[DATA_W-1:0];
            end
            RUN_TIME_HIGH_IDX: begin
                next_rdata = run_time[STAMP_W-1:DATA_W];
            end
            FAULT_COUNT_IDX: begin
                next_rdata = DATA_W'(record_count);
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data stand for one cycle after each cycle of rd_en, and read as zero otherwise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd_en) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end

    AST_LIVE_CURRENT: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == PHASE_CURRENT_RMS_IDX && $past(rst_n, 2)
        |=> rdata == $past(live_meas.phase_current, 2))
        else $error("live phase current read mismatch");

    AST_LIVE_BUS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == BUS_VOLTAGE_LIVE_IDX && $past(rst_n, 2)
        |=> rdata == $past(live_meas.bus_voltage, 2))
        else $error("live bus voltage read mismatch");

    AST_LIVE_TEMP: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == MODULE_TEMPERATURE_IDX && $past(rst_n, 2)
        |=> rdata == $past(live_meas.temperature, 2))
        else $error("module temperature read mismatch");

    AST_SELECT_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        wr_en && addr == FAULT_RECORD_SELECT_IDX
        |=> (record_select == $past(wdata[SEL_W-1:0]) && $past(wdata) <= DATA_W'(SEL_MAX))
            || ($stable(record_select) && $past(wdata) > DATA_W'(SEL_MAX)))
        else $error("record selector update wrong");

    AST_SELECT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        record_select <= SEL_MAX)
        else $error("record selector out of range");

    AST_EMPTY_CODE: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == SELECTED_FAULT_CODE_IDX && !records[record_select].valid
        |=> rdata == NO_FAULT_CODE)
        else $error("empty record shows nonzero code");

    AST_CODE_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == SELECTED_FAULT_CODE_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].code))
        else $error("selected fault code mismatch");

    AST_STAMP_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture |=> records[0].stamp == $past(run_time) && records[0].valid)
        else $error("fault timestamp not captured");

    AST_EMPTY_STAMP: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && (addr == STAMP_LOW_IDX || addr == STAMP_HIGH_IDX)
        && !records[record_select].valid |=> rdata == '0)
        else $error("empty record shows nonzero timestamp");

    AST_SPEED_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture && $past(rst_n) |=> records[0].speed == $past(live_meas.motor_speed, 2))
        else $error("fault speed not captured");

    AST_U_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture && $past(rst_n) |=> records[0].u_current == $past(live_meas.u_current, 2))
        else $error("fault U current not captured");

    AST_V_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture && $past(rst_n) |=> records[0].v_current == $past(live_meas.v_current, 2))
        else $error("fault V current not captured");

    AST_BUS_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        capture && $past(rst_n) |=> records[0].bus_voltage == $past(live_meas.bus_voltage, 2))
        else $error("fault bus voltage not captured");

    AST_EMPTY_SNAPSHOT: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr >= FAULT_MOTOR_SPEED_IDX && addr <= FAULT_BUS_VOLTAGE_IDX
        && !records[record_select].valid |=> rdata == '0)
        else $error("empty record shows nonzero snapshot");

    AST_SHIFT: assert property (@(posedge clock) disable iff (!rst_n)
        capture |=> records[RECORD_DEPTH-1] == $past(records[RECORD_DEPTH-2])
                 && records[1] == $past(records[0]))
        else $error("records did not age by one place");

    AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !capture |=> $stable(records[RECORD_DEPTH-1]) && $stable(records[0]))
        else $error("records changed without a fault");

    AST_RESET_EMPTY: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> !records[0].valid && !records[RECORD_DEPTH-1].valid
                      && record_count == '0)
        else $error("records not empty after reset");

    AST_RESET_SELECT: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> record_select == SEL_RESET && run_time == '0)
        else $error("selector or running time not cleared by reset");

    AST_STAMP_LOW_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == STAMP_LOW_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].stamp[DATA_W-1:0]))
        else $error("selected timestamp low half mismatch");

    AST_STAMP_HIGH_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == STAMP_HIGH_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].stamp[STAMP_W-1:DATA_W]))
        else $error("selected timestamp high half mismatch");

    AST_SPEED_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == FAULT_MOTOR_SPEED_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].speed))
        else $error("selected fault speed mismatch");

    AST_U_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == FAULT_U_CURRENT_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].u_current))
        else $error("selected fault U current mismatch");

    AST_V_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == FAULT_V_CURRENT_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].v_current))
        else $error("selected fault V current mismatch");

    AST_BUS_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == FAULT_BUS_VOLTAGE_IDX && records[record_select].valid
        |=> rdata == $past(records[record_select].bus_voltage))
        else $error("selected fault bus voltage mismatch");

endmodule

// ---- inc/fault_history_pkg.sv ----
package fault_history_pkg;

    localparam int DATA_W       = 16;
    localparam int ADDR_W       = 4;
    localparam int STAMP_W      = 32;
    localparam int SEL_W        = 4;
    localparam int RECORD_DEPTH = 10;

    localparam logic [DATA_W-1:0] NO_FAULT_CODE = 16'h0000;
    localparam logic [SEL_W-1:0]  SEL_MAX       = 4'h9;
    localparam logic [SEL_W-1:0]  SEL_RESET     = 4'h0;

    // Register indices on the plain register port
    localparam logic [ADDR_W-1:0] PHASE_CURRENT_RMS_IDX  = 4'h0;
    localparam logic [ADDR_W-1:0] BUS_VOLTAGE_LIVE_IDX   = 4'h1;
    localparam logic [ADDR_W-1:0] MODULE_TEMPERATURE_IDX = 4'h2;
    localparam logic [ADDR_W-1:0] FAULT_RECORD_SELECT_IDX = 4'h3;
    localparam logic [ADDR_W-1:0] SELECTED_FAULT_CODE_IDX = 4'h4;
    localparam logic [ADDR_W-1:0] STAMP_LOW_IDX          = 4'h5;
    localparam logic [ADDR_W-1:0] STAMP_HIGH_IDX         = 4'h6;
    localparam logic [ADDR_W-1:0] FAULT_MOTOR_SPEED_IDX  = 4'h7;
    localparam logic [ADDR_W-1:0] FAULT_U_CURRENT_IDX    = 4'h8;
    localparam logic [ADDR_W-1:0] FAULT_V_CURRENT_IDX    = 4'h9;
    localparam logic [ADDR_W-1:0] FAULT_BUS_VOLTAGE_IDX  = 4'ha;
    localparam logic [ADDR_W-1:0] RUN_TIME_LOW_IDX       = 4'hb;
    localparam logic [ADDR_W-1:0] RUN_TIME_HIGH_IDX      = 4'hc;
    localparam logic [ADDR_W-1:0] FAULT_COUNT_IDX        = 4'hd;

    // Running time counts in 0.1 s steps
    localparam int CLOCK_PERIOD_NS  = 50;
    localparam int RUN_TIME_UNIT_NS = 100_000_000;
    localparam int RUN_TICK_CYCLES  = RUN_TIME_UNIT_NS / CLOCK_PERIOD_NS;

    typedef struct packed {
        logic [DATA_W-1:0] phase_current;
        logic [DATA_W-1:0] bus_voltage;
        logic [DATA_W-1:0] temperature;
        logic [DATA_W-1:0] motor_speed;
        logic [DATA_W-1:0] u_current;
        logic [DATA_W-1:0] v_current;
    } meas_t;

    typedef struct packed {
        logic               valid;
        logic [DATA_W-1:0]  code;
        logic [STAMP_W-1:0] stamp;
        logic [DATA_W-1:0]  speed;
        logic [DATA_W-1:0]  u_current;
        logic [DATA_W-1:0]  v_current;
        logic [DATA_W-1:0]  bus_voltage;
    } fault_rec_t;

    localparam fault_rec_t EMPTY_RECORD = '0;

endpackage

// ---- tb/fault_history_recorder_tb.sv ----
`timescale 1ns/1ps
module fault_history_recorder_tb;
    import fault_history_pkg::*;

    // Short running-time step keeps the run brief
    localparam int TICK = 10;

    logic              clock;
    logic              rst_n;
    meas_t             live_meas;
    logic              drive_running;
    logic              fault_event;
    logic [DATA_W-1:0] fault_code;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    int                miscompares;
    int                samples_checked;
    int                run_cycles;
    logic [31:0]       seed;
    logic [31:0]       rnd;
    meas_t             m;
    fault_rec_t        model_q[$];

    fault_history_recorder #(.TICK_CYCLES(TICK)) i_dut (
        .clock(clock), .rst_n(rst_n), .live_meas(live_meas), .drive_running(drive_running),
        .fault_event(fault_event), .fault_code(fault_code), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic meas_t rand_meas();
        return {next_rand(), next_rand(), next_rand()};
    endfunction

    function automatic logic [DATA_W-1:0] exp_field(input int s, input logic [ADDR_W-1:0] a);
        fault_rec_t e;
        e = (s < model_q.size()) ? model_q[s] : EMPTY_RECORD;
        case (a)
            SELECTED_FAULT_CODE_IDX: return e.code;
            STAMP_LOW_IDX:           return e.stamp[15:0];
            STAMP_HIGH_IDX:          return e.stamp[31:16];
            FAULT_MOTOR_SPEED_IDX:   return e.speed;
            FAULT_U_CURRENT_IDX:     return e.u_current;
            FAULT_V_CURRENT_IDX:     return e.v_current;
            default:                 return e.bus_voltage;
        endcase
    endfunction

    task automatic end_sim();
        $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        samples_checked++;
        if (rdata !== exp) begin
            miscompares++;
            $display("BAD t=%0t addr=%h exp=%h got=%h", $time, a, exp, rdata);
        end
    endtask

    task automatic check_records();
        for (int s = 0; s < RECORD_DEPTH; s++) begin
            wr(FAULT_RECORD_SELECT_IDX, DATA_W'(s));
            for (int a = 4; a <= 10; a++) begin
                rd_chk(ADDR_W'(a), exp_field(s, ADDR_W'(a)));
            end
        end
    endtask

    task automatic run(input int n);
        @(posedge clock);
        drive_running <= 1'b1;
        repeat (n) @(posedge clock);
        drive_running <= 1'b0;
        run_cycles += n;
    endtask

    // Running time is held still around faults so the stamp is exact
    task automatic fault(input logic [DATA_W-1:0] c1, input logic [DATA_W-1:0] c2, input meas_t mm);
        logic [DATA_W-1:0] codes[2];
        codes = '{c1, c2};
        @(posedge clock);
        live_meas <= mm;
        @(posedge clock);
        fault_event <= 1'b1;
        fault_code  <= c1;
        if (c2 != 16'h0000) begin
            @(posedge clock);
            fault_code <= c2;
        end
        @(posedge clock);
        fault_event <= 1'b0;
        foreach (codes[k]) begin
            if (codes[k] != 16'h0000) begin
                model_q.push_front('{1'b1, codes[k], 32'(run_cycles / TICK), mm.motor_speed,
                                    mm.u_current, mm.v_current, mm.bus_voltage});
                if (model_q.size() > RECORD_DEPTH) void'(model_q.pop_back());
            end
        end
    endtask

    initial begin
        #(20000 * 50);
        miscompares++;
        end_sim();
    end

    initial begin
        seed = 32'h0d04;
        rst_n = 1'b0;
        live_meas = '0;
        drive_running = 1'b0;
        fault_event = 1'b0;
        fault_code = 16'h0000;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        run_cycles = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(FAULT_RECORD_SELECT_IDX, 16'h0000);
        check_records();
        $display("test reset_empty done");
        m = rand_meas();
        @(posedge clock);
        live_meas <= m;
        rd_chk(PHASE_CURRENT_RMS_IDX, m.phase_current);
        rd_chk(BUS_VOLTAGE_LIVE_IDX, m.bus_voltage);
        rd_chk(MODULE_TEMPERATURE_IDX, m.temperature);
        $display("test live_values done");
        run(37);
        for (int i = 0; i < 12; i++) begin
            rnd = next_rand() | 32'h1;
            fault(rnd[15:0], (i % 4 == 1) ? (rnd[15:0] ^ 16'h8000) : 16'h0000, rand_meas());
            if (i == 5) fault(16'h0000, 16'h0000, rand_meas());
            if (i == 6) run(13);
        end
        check_records();
        $display("test fault_history done");
        wr(FAULT_RECORD_SELECT_IDX, 16'h0003);
        wr(FAULT_RECORD_SELECT_IDX, 16'h000a);
        rd_chk(FAULT_RECORD_SELECT_IDX, 16'h0003);
        wr(SELECTED_FAULT_CODE_IDX, 16'hffff);
        rd_chk(SELECTED_FAULT_CODE_IDX, exp_field(3, SELECTED_FAULT_CODE_IDX));
        rd_chk(4'he, 16'h0000);
        rd_chk(FAULT_COUNT_IDX, DATA_W'(model_q.size()));
        rd_chk(RUN_TIME_LOW_IDX, DATA_W'(run_cycles / TICK));
        rd_chk(RUN_TIME_HIGH_IDX, 16'h0000);
        $display("test selector_limits done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        model_q.delete();
        run_cycles = 0;
        rd_chk(FAULT_RECORD_SELECT_IDX, 16'h0000);
        rd_chk(FAULT_COUNT_IDX, 16'h0000);
        check_records();
        run(TICK + 4);
        fault(16'h00a5, 16'h0000, rand_meas());
        rd_chk(RUN_TIME_LOW_IDX, DATA_W'(run_cycles / TICK));
        check_records();
        $display("test mid_reset done");
        end_sim();
    end
endmodule
